/* design/fsq_pkg.sv */
// package: constants and carriers for the flash secure-region and query host controller
package fsq_pkg;
    localparam logic [7:0]  CMD_UNLOCK1     = 8'hAA;
    localparam logic [7:0]  CMD_UNLOCK2     = 8'h55;
    localparam logic [7:0]  CMD_SEC_ENTER   = 8'h88;
    localparam logic [7:0]  CMD_SEC_EXIT1   = 8'h90;
    localparam logic [7:0]  CMD_SEC_EXIT2   = 8'h00;
    localparam logic [7:0]  CMD_QUERY       = 8'h98;
    localparam logic [7:0]  CMD_RESET       = 8'hF0;
    localparam logic [7:0]  CMD_PROGRAM     = 8'hA0;
    localparam logic [19:0] ADR_UNLOCK1_W   = 20'h0_0555;
    localparam logic [19:0] ADR_UNLOCK2_W   = 20'h0_02AA;
    localparam logic [19:0] ADR_QUERY_W     = 20'h0_0055;
    localparam logic [19:0] ADR_QUERY_B     = 20'h0_00AA;
    localparam logic [19:0] ADR_SER_BOT_W   = 20'h0_0000;
    localparam logic [19:0] ADR_SER_TOP_W   = 20'h0_FFF8;
    localparam logic [20:0] ADR_SER_TOP_B   = 21'h01_FFF0;
    localparam logic [7:0]  LOCK_GROUP_ADR  = 8'h1A;
    localparam int          LOCK_BIT_POS    = 7;
    localparam logic [5:0]  QRY_FIRST       = 6'h10;
    localparam logic [5:0]  QRY_LAST        = 6'h26;
    localparam int          SER_WORDS       = 8;
    localparam int          QRY_WORDS       = 23;
    localparam real         T_CYC_NS        = 100.0;
    localparam real         CLK_NS          = 25.0;
    localparam int          CYC_BUS         = int'($ceil(T_CYC_NS / CLK_NS));
    localparam logic [3:0]  BUS_CYCLES      = 4'(CYC_BUS);

    typedef enum logic [2:0] {
        FSQ_OP_SEC_ENTER,
        FSQ_OP_SEC_EXIT,
        FSQ_OP_QUERY_READ,
        FSQ_OP_SER_READ,
        FSQ_OP_SEC_PROGRAM,
        FSQ_OP_LOCK_SETUP,
        FSQ_OP_INDICATOR
    } fsq_op_type;

    typedef struct packed {
        fsq_op_type  op;
        logic        byte_mode;
        logic        top_boot;
        logic [19:0] addr;
        logic [15:0] data;
    } fsq_req_type;

    typedef struct packed {
        logic [19:0] addr;
        logic [15:0] dq_out;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        dq_oe;
    } fsq_pins_type;

    typedef struct packed {
        logic        ok;
        logic        factory_locked;
        logic        qry_bad;
        logic [15:0] data;
    } fsq_resp_type;
endpackage

/* design/fsq_bus_cycle.sv */
// single asynchronous flash bus cycle: write or read with fixed strobe length
`timescale 1ns/1ps
module fsq_bus_cycle import fsq_pkg::*; (
    input  wire logic        core_clk,   // 40 MHz clock
    input  wire logic        rst_n,      // sync reset, active low
    input  wire logic        ce,         // clock enable
    input  wire logic        start,      // begin one cycle
    input  wire logic        is_write,   // write when high, read when low
    input  wire logic [19:0] addr,       // address for the cycle
    input  wire logic [15:0] wdata,      // write data
    input  wire logic [15:0] dq_in,      // data pins from device
    output fsq_pins_type     pins,       // registered bus pins
    output logic             done,       // one-cycle completion pulse
    output logic [15:0]      rdata       // captured read data
);
    logic [3:0] cnt_q;
    logic       busy_q;
    logic       wr_q;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            cnt_q  <= 4'h0;
            wr_q   <= 1'b0;
            done   <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            if (start && !busy_q) begin
                busy_q <= 1'b1;
                cnt_q  <= BUS_CYCLES;
                wr_q   <= is_write;
            end else if (busy_q) begin
                if (cnt_q == 4'h0) begin
                    busy_q <= 1'b0;
                    done   <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 4'h1;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pins  <= '{addr: 20'h0_0000, dq_out: 16'h0000, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0};
            rdata <= 16'h0000;
        end else if (ce) begin
            if (start && !busy_q) begin
                pins.addr   <= addr;
                pins.dq_out <= wdata;
                pins.ce_n   <= 1'b0;
                pins.oe_n   <= is_write;
                pins.we_n   <= !is_write;
                pins.dq_oe  <= is_write;
            end else if (busy_q && cnt_q == 4'h0) begin
                // data sampled while oe is still low, strobes then lifted together
                if (!wr_q) begin
                    rdata <= dq_in;
                end
                pins.ce_n  <= 1'b1;
                pins.oe_n  <= 1'b1;
                pins.we_n  <= 1'b1;
                pins.dq_oe <= 1'b0;
            end
        end
    end
endmodule

/* design/fsq_host.sv */
// host controller for the flash secure region and query table
`timescale 1ns/1ps
module fsq_host import fsq_pkg::*; (
    input  wire logic         core_clk,    // 40 MHz clock
    input  wire logic         rst_n,       // sync reset, active low
    input  wire logic         clk_en,      // freezes all state when low
    input  wire logic         req_valid,   // request strobe
    input  fsq_req_type       req,         // operation and operands
    output logic              req_ready,   // idle, request accepted when valid
    output fsq_resp_type      resp,        // result of last operation
    output logic              resp_valid,  // one-cycle result pulse
    output logic              in_secure,   // device believed in secure mode
    output logic              in_query,    // device believed in query mode
    input  wire logic [15:0]  dq_in,       // flash data pins in
    output fsq_pins_type      pins         // flash address, data and strobes
);
    typedef enum logic [1:0] {ST_IDLE, ST_SEQ, ST_WAIT} fsq_state_type;

    fsq_state_type st_q;
    fsq_req_type   cur_q;
    logic [4:0]    step_q;
    logic [3:0]    ser_idx_q;
    logic [4:0]    qry_idx_q;
    logic          qry_bad_q;
    logic          locked_q;
    logic          start;
    logic          is_write;
    logic [19:0]   cyc_addr;
    logic [15:0]   cyc_data;
    logic          last;
    logic          done;
    logic [15:0]   rdata;

    // expected query contents, word 10h upward
    function automatic logic [15:0] qry_expect(input logic [4:0] i);
        case (i)
            5'h00: qry_expect = 16'h0051;
            5'h01: qry_expect = 16'h0052;
            5'h02: qry_expect = 16'h0059;
            5'h03: qry_expect = 16'h0002;
            5'h05: qry_expect = 16'h0040;
            5'h0B: qry_expect = 16'h0027;
            5'h0C: qry_expect = 16'h0036;
            5'h0F: qry_expect = 16'h0003;
            5'h11: qry_expect = 16'h0009;
            5'h13: qry_expect = 16'h0005;
            5'h15: qry_expect = 16'h0004;
            default: qry_expect = 16'h0000;
        endcase
    endfunction

    // word address to pin address; byte mode doubles it
    function automatic logic [19:0] map_addr(input logic bm, input logic [19:0] w);
        map_addr = bm ? {w[18:0], 1'b0} : w;
    endfunction

    fsq_bus_cycle u_cycle (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .ce       (clk_en),
        .start    (start),
        .is_write (is_write),
        .addr     (cyc_addr),
        .wdata    (cyc_data),
        .dq_in    (dq_in),
        .pins     (pins),
        .done     (done),
        .rdata    (rdata)
    );

    // per-step cycle generation
    always_comb begin
        is_write = 1'b1;
        cyc_addr = map_addr(cur_q.byte_mode, ADR_UNLOCK1_W);
        cyc_data = {8'h00, CMD_UNLOCK1};
        last     = 1'b0;
        case (step_q)
            5'd0: ;
            5'd1: begin
                cyc_addr = map_addr(cur_q.byte_mode, ADR_UNLOCK2_W);
                cyc_data = {8'h00, CMD_UNLOCK2};
            end
            default: begin
                case (cur_q.op)
                    FSQ_OP_SEC_ENTER: begin
                        cyc_data = {8'h00, CMD_SEC_ENTER};
                        last     = 1'b1;
                    end
                    FSQ_OP_SEC_EXIT: begin
                        cyc_data = step_q == 5'd2 ? {8'h00, CMD_SEC_EXIT1} : {8'h00, CMD_SEC_EXIT2};
                        last     = step_q == 5'd3;
                    end
                    FSQ_OP_SEC_PROGRAM: begin
                        // full unlock each word, never the bypass shortcut
                        cyc_data = {8'h00, CMD_PROGRAM};
                        if (step_q == 5'd3) begin
                            cyc_addr = map_addr(cur_q.byte_mode, cur_q.addr);
                            cyc_data = cur_q.data;
                            last     = 1'b1;
                        end
                    end
                    FSQ_OP_LOCK_SETUP: begin
                        // sector group address for the region; protect pulses run outside
                        cyc_addr = {12'h000, LOCK_GROUP_ADR};
                        cyc_data = 16'h0000;
                        is_write = 1'b0;
                        last     = 1'b1;
                    end
                    FSQ_OP_QUERY_READ: begin
                        if (step_q == 5'd2) begin
                            cyc_addr = cur_q.byte_mode ? {12'h000, ADR_QUERY_B[7:0]} : ADR_QUERY_W;
                            cyc_data = {8'h00, CMD_QUERY};
                        end else if (step_q == 5'd3) begin
                            is_write = 1'b0;
                            // upper word address bits forced to zero
                            cyc_addr = map_addr(cur_q.byte_mode, {14'h0000, QRY_FIRST + {1'b0, qry_idx_q}});
                        end else begin
                            cyc_data = {8'h00, CMD_RESET};
                            last     = 1'b1;
                        end
                    end
                    FSQ_OP_SER_READ: begin
                        is_write = 1'b0;
                        cyc_addr = cur_q.top_boot
                            ? (cur_q.byte_mode ? ADR_SER_TOP_B[19:0] + {16'h0000, ser_idx_q}
                                               : ADR_SER_TOP_W + {17'h0_0000, ser_idx_q[2:0]})
                            : (cur_q.byte_mode ? {16'h0000, ser_idx_q}
                                               : ADR_SER_BOT_W + {17'h0_0000, ser_idx_q[2:0]});
                        last     = ser_idx_q == (cur_q.byte_mode ? 4'hF : 4'(SER_WORDS - 1));
                    end
                    default: begin
                        is_write = 1'b0;
                        cyc_addr = 20'h0_0000;
                        last     = 1'b1;
                    end
                endcase
            end
        endcase
    end

    // serial and indicator reads and lock setup need no unlock prefix
    function automatic logic [4:0] first_step(input fsq_op_type o);
        first_step = (o == FSQ_OP_SER_READ || o == FSQ_OP_LOCK_SETUP || o == FSQ_OP_INDICATOR) ? 5'd2 : 5'd0;
    endfunction

    assign start = (st_q == ST_SEQ);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_q       <= ST_IDLE;
            step_q     <= 5'd0;
            cur_q      <= '0;
            ser_idx_q  <= 4'h0;
            qry_idx_q  <= 5'd0;
            qry_bad_q  <= 1'b0;
            req_ready  <= 1'b1;
            resp_valid <= 1'b0;
            resp       <= '0;
        end else if (clk_en) begin
            resp_valid <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (req_valid && req_ready) begin
                        cur_q     <= req;
                        step_q    <= first_step(req.op);
                        ser_idx_q <= 4'h0;
                        qry_idx_q <= 5'd0;
                        qry_bad_q <= 1'b0;
                        req_ready <= 1'b0;
                        st_q      <= ST_SEQ;
                    end
                end
                ST_SEQ: st_q <= ST_WAIT;
                ST_WAIT: begin
                    if (done) begin
                        st_q <= ST_SEQ;
                        if (cur_q.op == FSQ_OP_QUERY_READ && step_q == 5'd3) begin
                            if ((cur_q.byte_mode ? {8'h00, rdata[7:0]} : rdata) != qry_expect(qry_idx_q)) begin
                                qry_bad_q <= 1'b1;
                            end
                            if (qry_idx_q == 5'(QRY_WORDS - 1)) begin
                                step_q <= 5'd4;
                            end
                            qry_idx_q <= qry_idx_q + 5'd1;
                        end else if (cur_q.op == FSQ_OP_SER_READ && !last) begin
                            ser_idx_q <= ser_idx_q + 4'h1;
                        end else if (!last) begin
                            step_q <= step_q + 5'd1;
                        end
                        if (cur_q.op == FSQ_OP_SER_READ || cur_q.op == FSQ_OP_INDICATOR) begin
                            resp.data <= rdata;
                        end
                        if (cur_q.op == FSQ_OP_INDICATOR) begin
                            resp.factory_locked <= rdata[LOCK_BIT_POS];
                        end
                        if (last) begin
                            st_q       <= ST_IDLE;
                            req_ready  <= 1'b1;
                            resp_valid <= 1'b1;
                            resp.qry_bad <= qry_bad_q;
                            // programming a locked region still runs on the bus; only resp.ok is cleared
                            resp.ok    <= !(cur_q.op == FSQ_OP_SEC_PROGRAM && locked_q);
                        end
                        if (cur_q.op == FSQ_OP_SER_READ) begin
                            resp_valid <= 1'b1;
                        end
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // mode tracking mirrors the device; reset returns normal mode
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            in_secure <= 1'b0;
            in_query  <= 1'b0;
            locked_q  <= 1'b0;
        end else if (clk_en && st_q == ST_WAIT && done && last) begin
            case (cur_q.op)
                FSQ_OP_SEC_ENTER:  in_secure <= 1'b1;
                FSQ_OP_SEC_EXIT:   in_secure <= 1'b0;
                FSQ_OP_INDICATOR:  locked_q  <= locked_q | rdata[LOCK_BIT_POS];
                FSQ_OP_LOCK_SETUP: locked_q  <= 1'b1;
                default: ;
            endcase
            in_query <= 1'b0;
        end else if (clk_en && st_q == ST_WAIT && done && cur_q.op == FSQ_OP_QUERY_READ && step_q == 5'd2) begin
            in_query <= 1'b1;
        end
    end
endmodule

/* testbench/fsq_host_monitor.sv */
// checker: bus pin and mode tracking relations of the flash host controller
`timescale 1ns/1ps
module fsq_host_monitor import fsq_pkg::*; (
    input  wire logic         core_clk,    // clock
    input  wire logic         rst_n,       // sync reset, active low
    input  wire logic         clk_en,      // clock enable
    input  wire logic         req_valid,   // request strobe
    input  fsq_req_type       req,         // request
    input  wire logic         req_ready,   // idle
    input  fsq_resp_type      resp,        // result
    input  wire logic         resp_valid,  // result pulse
    input  wire logic         in_secure,   // secure mode flag
    input  wire logic         in_query,    // query mode flag
    input  wire logic [15:0]  dq_in,       // flash data in
    input  fsq_pins_type      pins         // flash pins
);
    logic [7:0] cmd1_q;
    logic [7:0] cmd2_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // last two command bytes, taken as each write strobe starts
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cmd1_q <= 8'h00;
            cmd2_q <= 8'h00;
        end else if ($fell(pins.we_n) && !pins.ce_n) begin
            cmd1_q <= pins.dq_out[7:0];
            cmd2_q <= cmd1_q;
        end
    end

    sequence wr_start;
        $fell(pins.we_n) && !pins.ce_n;
    endsequence

    rst_idle_a: assert property (disable iff (1'b0) !rst_n |=> req_ready && pins.ce_n && pins.we_n
        && pins.oe_n && !pins.dq_oe && !resp_valid && !in_secure && !in_query)
        else $error("pins or modes not idle after reset");
    write_drive_a: assert property (!pins.we_n |-> pins.dq_oe && !pins.ce_n && pins.oe_n)
        else $error("write strobe without data drive");
    strobe_len_a: assert property (wr_start |-> (!pins.we_n)[*4])
        else $error("write strobe shorter than four cycles");
    write_hold_a: assert property (!pins.we_n && $past(!pins.we_n) |-> $stable(pins.addr) && $stable(pins.dq_out))
        else $error("address or data moved during write");
    sec_enter_a: assert property ($rose(in_secure) |-> cmd1_q == CMD_SEC_ENTER && cmd2_q == CMD_UNLOCK2)
        else $error("secure mode without entry sequence");
    sec_exit_a: assert property ($fell(in_secure) |-> cmd1_q == CMD_SEC_EXIT2 && cmd2_q == CMD_SEC_EXIT1)
        else $error("secure mode left without exit sequence");
    prog_unlock_a: assert property (wr_start ##0 (pins.dq_out[7:0] == CMD_PROGRAM && pins.addr == ADR_UNLOCK1_W)
        |-> cmd1_q == CMD_UNLOCK2 && cmd2_q == CMD_UNLOCK1)
        else $error("program command without full unlock");
    query_cmd_a: assert property (wr_start ##0 (pins.dq_out[7:0] == CMD_QUERY)
        |-> pins.addr == ADR_QUERY_W || pins.addr == ADR_QUERY_B)
        else $error("query command at wrong address");
    query_addr_a: assert property (in_query && !pins.oe_n |-> pins.addr[19:7] == 13'h0000)
        else $error("query read with upper address bits set");
    query_enter_a: assert property ($rose(in_query) |-> cmd1_q == CMD_QUERY)
        else $error("query mode without query command");
    query_exit_a: assert property ($fell(in_query) |-> cmd1_q == CMD_RESET)
        else $error("query mode left without reset command");
endmodule

bind fsq_host fsq_host_monitor u_mon (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .resp(resp), .resp_valid(resp_valid),
    .in_secure(in_secure), .in_query(in_query), .dq_in(dq_in), .pins(pins));

/* testbench/fsq_flash_model.sv */
// behavioural flash device: command decode, secure region, query table
`timescale 1ns/1ps
module fsq_flash_model import fsq_pkg::*; #(
    parameter bit FACTORY = 1'b0          // factory-locked part when set
) (
    input  wire logic         core_clk,   // sampling clock
    input  fsq_pins_type      pins,       // host pins
    input  wire logic         byte_mode,  // width strap
    input  wire logic         corrupt,    // flips one query entry
    output logic [15:0]       dq_in       // data to host
);
    logic [15:0] sec_mem [0:127];  // 256-byte region apart from the array
    logic [15:0] last_q;
    logic [15:0] wd_q;
    logic [15:0] rd;
    logic [19:0] wa_q;
    logic [5:0]  qi;
    logic [1:0]  seq_q;
    logic        wr_q;
    logic        prog_q;
    logic        secure_q;
    logic        query_q;

    function automatic logic [15:0] qv(input logic [5:0] i);
        case (i)
            6'h10: qv = 16'h0051;
            6'h11: qv = 16'h0052;
            6'h12: qv = 16'h0059;
            6'h13: qv = 16'h0002;
            6'h15: qv = 16'h0040;
            6'h1B: qv = 16'h0027;
            6'h1C: qv = 16'h0036;
            6'h1F: qv = 16'h0003;
            6'h21: qv = 16'h0009;
            6'h23: qv = 16'h0005;
            6'h25: qv = 16'h0004;
            default: qv = 16'h0000;
        endcase
    endfunction

    // power-up state: array routing, region holds a serial pattern
    initial begin
        for (int i = 0; i < 128; i++) sec_mem[i] = 16'(16'h5E00 + i);
        {last_q, wd_q, wa_q, seq_q, wr_q, prog_q, secure_q, query_q} = '0;
    end

    always_comb begin
        qi = byte_mode ? pins.addr[6:1] : pins.addr[5:0];
        if (query_q) rd = qv(qi) ^ {15'h0000, corrupt && qi == 6'h13};
        else if (secure_q) rd = sec_mem[pins.addr[6:0]];
        else if (pins.addr == 20'h0_0000) rd = {8'h00, FACTORY, 7'h16};
        else rd = ~pins.addr[15:0];
        // undriven bus shows the inverse of the last value, not a held copy
        dq_in = (!pins.ce_n && !pins.oe_n) ? rd : ~last_q;
    end

    always @(posedge core_clk) begin
        if (!pins.ce_n && !pins.oe_n) last_q <= rd;
        if (!pins.ce_n && !pins.we_n) begin
            wr_q <= 1'b1;
            wa_q <= pins.addr;
            wd_q <= pins.dq_out;
        end else if (wr_q) begin
            wr_q <= 1'b0;
            seq_q <= 2'h0;
            if (prog_q) begin
                prog_q <= 1'b0;
                // flash programming only clears bits; factory part refuses
                if (secure_q && !FACTORY) sec_mem[wa_q[6:0]] <= sec_mem[wa_q[6:0]] & wd_q;
            end
            else if (wd_q[7:0] == CMD_RESET) query_q <= 1'b0;
            else if (wd_q[7:0] == CMD_QUERY && wa_q == (byte_mode ? ADR_QUERY_B : ADR_QUERY_W)) query_q <= 1'b1;
            else if (seq_q == 2'h0 && wd_q[7:0] == CMD_UNLOCK1 && wa_q == ADR_UNLOCK1_W) seq_q <= 2'h1;
            else if (seq_q == 2'h1 && wd_q[7:0] == CMD_UNLOCK2 && wa_q == ADR_UNLOCK2_W) seq_q <= 2'h2;
            else if (seq_q == 2'h2 && wd_q[7:0] == CMD_SEC_ENTER) secure_q <= 1'b1;
            else if (seq_q == 2'h2 && wd_q[7:0] == CMD_SEC_EXIT1) seq_q <= 2'h3;
            else if (seq_q == 2'h3 && wd_q[7:0] == CMD_SEC_EXIT2) secure_q <= 1'b0;
            else if (seq_q == 2'h2 && wd_q[7:0] == CMD_PROGRAM) prog_q <= 1'b1;
        end
    end
endmodule

/* testbench/fsq_host_test.sv */
// testbench: host controller against the behavioural flash device
`timescale 1ns/1ps
module fsq_host_test import fsq_pkg::*; ;
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_errors++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
    logic         core_clk  = 1'b0;
    logic         rst_n     = 1'b0;
    logic         clk_en    = 1'b1;
    logic         req_valid = 1'b0;
    logic         byte_mode = 1'b0;
    logic         corrupt   = 1'b0;
    fsq_req_type  req       = '0;
    logic         req_ready;
    logic         resp_valid;
    logic         in_secure;
    logic         in_query;
    logic [15:0]  dq_in;
    fsq_resp_type resp;
    fsq_pins_type pins;
    fsq_resp_type got [0:7];
    int           n_errors        = 0;
    int           samples_checked = 0;
    int           cyc             = 0;

    always #12.5 core_clk = ~core_clk;

    fsq_host DUT (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .resp(resp), .resp_valid(resp_valid), .in_secure(in_secure),
        .in_query(in_query), .dq_in(dq_in), .pins(pins));
    fsq_flash_model #(.FACTORY(1'b0)) u_flash (.core_clk(core_clk), .pins(pins), .byte_mode(byte_mode),
        .corrupt(corrupt), .dq_in(dq_in));

    task automatic tally_and_finish;
        if (n_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // one request, then collect n result pulses
    task automatic run(input fsq_op_type op, input logic bm, input logic tb, input logic [19:0] a,
                       input logic [15:0] d, input int n);
        int k;
        int c;
        @(posedge core_clk);
        req_valid <= 1'b1;
        req <= '{op: op, byte_mode: bm, top_boot: tb, addr: a, data: d};
        byte_mode <= bm;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (req_ready !== 1'b1 && k < 100);
        req_valid <= 1'b0;
        c = 0;
        for (k = 0; k < 3000 && c < n; k++) begin
            @(negedge core_clk);
            if (resp_valid === 1'b1) begin
                got[c] = resp;
                c++;
            end
        end
        `CHK("result count", n, c)
    endtask

    task automatic t_reset;
        @(negedge core_clk);
        `CHK("ready after reset", 1'b1, req_ready)
        `CHK("secure after reset", 1'b0, in_secure)
        `CHK("query after reset", 1'b0, in_query)
        `CHK("chip select idle", 1'b1, pins.ce_n)
    endtask

    task automatic t_indicator;
        run(FSQ_OP_INDICATOR, 1'b0, 1'b0, 20'h0_0000, 16'h0000, 1);
        `CHK("lock indicator", 1'b0, got[0].factory_locked)
    endtask

    task automatic t_query;
        for (int b = 0; b < 2; b++) begin
            run(FSQ_OP_QUERY_READ, b[0], 1'b0, 20'h0_0000, 16'h0000, 1);
            `CHK("query table good", 1'b0, got[0].qry_bad)
            `CHK("query mode left", 1'b0, in_query)
        end
        corrupt <= 1'b1;
        run(FSQ_OP_QUERY_READ, 1'b0, 1'b0, 20'h0_0000, 16'h0000, 1);
        `CHK("query table bad", 1'b1, got[0].qry_bad)
        corrupt <= 1'b0;
    endtask

    task automatic t_secure;
        run(FSQ_OP_SEC_ENTER, 1'b0, 1'b0, 20'h0_0000, 16'h0000, 1);
        `CHK("secure entered", 1'b1, in_secure)
        run(FSQ_OP_SER_READ, 1'b0, 1'b0, 20'h0_0000, 16'h0000, 8);
        for (int i = 0; i < 8; i++) `CHK("serial bottom", 16'(16'h5E00 + i), got[i].data)
        run(FSQ_OP_SER_READ, 1'b0, 1'b1, 20'h0_0000, 16'h0000, 8);
        for (int i = 0; i < 8; i++) `CHK("serial top", 16'(16'h5E78 + i), got[i].data)
        run(FSQ_OP_SEC_PROGRAM, 1'b0, 1'b0, 20'h0_0003, 16'h0F0F, 1);
        `CHK("program accepted", 1'b1, got[0].ok)
        run(FSQ_OP_SER_READ, 1'b0, 1'b0, 20'h0_0000, 16'h0000, 8);
        `CHK("programmed word", 16'h0E03, got[3].data)
        run(FSQ_OP_LOCK_SETUP, 1'b0, 1'b0, 20'h0_0000, 16'h0000, 1);
        run(FSQ_OP_SEC_PROGRAM, 1'b0, 1'b0, 20'h0_0004, 16'h0000, 1);
        `CHK("program after lock", 1'b0, got[0].ok)
        run(FSQ_OP_SEC_EXIT, 1'b0, 1'b0, 20'h0_0000, 16'h0000, 1);
        `CHK("secure left", 1'b0, in_secure)
        // array routing back: indicator read at address zero works again
        run(FSQ_OP_INDICATOR, 1'b0, 1'b0, 20'h0_0000, 16'h0000, 1);
        `CHK("indicator after exit", 1'b0, got[0].factory_locked)
        // secure word 0 would read 5E00h here, so this tells the routing apart
        `CHK("array data after exit", 16'h0016, got[0].data)
    endtask

    // clock enable low: a pending request must not be taken
    task automatic t_freeze;
        @(posedge core_clk);
        clk_en    <= 1'b0;
        req_valid <= 1'b1;
        req       <= '{op: FSQ_OP_SEC_ENTER, byte_mode: 1'b0, top_boot: 1'b0, addr: 20'h0_0000, data: 16'h0000};
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        `CHK("ready while frozen", 1'b1, req_ready)
        `CHK("strobe while frozen", 1'b1, pins.ce_n)
        @(posedge core_clk);
        clk_en    <= 1'b1;
        req_valid <= 1'b0;
        @(negedge core_clk);
        `CHK("secure after freeze", 1'b0, in_secure)
    endtask

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish;
        end
    end

    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset;
        t_freeze;
        t_indicator;
        t_query;
        t_secure;
        tally_and_finish;
    end
endmodule
